/* File: edge_sampler.sv */
/*
  Two-flop synchroniser for a group of pins with an edge finder behind it.
  Assumes all inputs come from outside the clk domain.
*/
`timescale 1ns/1ps
module edge_sampler
  import flash_pin_pkg::*;
#(
  parameter int               WIDTH = 8,
  parameter logic [WIDTH-1:0] IDLE  = '0
)(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } sampler_t;

  sampler_t state_reg;
  sampler_t state_next;

  // Every flop starts at its pin's idle level, so no false edge follows reset.
  // A select held low through reset is thus no falling edge and arms nothing.
  always_comb
  begin
    state_next      = state_reg;
    state_next.meta = pinIn;
    state_next.sync = state_reg.meta;
    state_next.last = state_reg.sync;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= '{meta: IDLE, sync: IDLE, last: IDLE};
    else
      state_reg <= state_next;
  end

  assign level = state_reg.sync;
  assign rise  = state_reg.sync & ~state_reg.last;
  assign fall  = ~state_reg.sync & state_reg.last;
endmodule

/* File: flash_host_model.sv */
/*
  Host controller model on the flash pins: select, serial clock and lanes.
  Assumes the bench moves select, reset and pause through this model's variables.
*/
`timescale 1ns/1ps
module flash_host_model
  import flash_pin_pkg::*;
#(
  parameter int HALF_NS = 40
)(
  input  wire logic       clk,
  output logic            selectPin_n,
  output logic            serialClkPin,
  output logic            resetPin_n,
  output logic            pausePin_n,
  output logic [3:0]      dqIn,
  input  wire logic [3:0] dqOut,
  input  wire logic [3:0] dqOe
);
  int slowBy = 1;
  bit idle   = 1'b1;

  // ****
  // Pins
  // ****
  // Select starts low, so the first frame after power-up lacks its falling edge.
  initial
  begin
    selectPin_n  = 1'b0;
    serialClkPin = 1'b0;
    resetPin_n   = 1'b1;
    pausePin_n   = 1'b1;
    dqIn         = 4'h5;
  end

  // Between transfers all lanes keep changing so that a stale level never passes for data.
  always @(negedge clk)
    if (idle)
      dqIn <= ~dqIn;

  // One byte each way, MSB first; the serial clock stands low between frames.
  task automatic xfer(input logic [7:0] txByte, output logic [7:0] rxByte);
    idle = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      dqIn[0] = txByte[i];
      #(HALF_NS * slowBy);
      serialClkPin = 1'b1;
      rxByte[i]    = dqOut[1] & dqOe[1];
      #(HALF_NS * slowBy);
      serialClkPin = 1'b0;
    end
    idle = 1'b1;
  endtask
endmodule

/* File: flash_pin_front.sv */
/*
  Pin-level front end of a serial NOR flash interface, with an AXI4-Lite
  register slave. Shifts command, address and data bytes on the flash pins
  and hands whole bytes to software.
  Assumes the host drives select, clock, reset and pause pins asynchronously,
  and that the serial clock is slow against clk (at least 4 clk per half).
*/
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module flash_pin_front
  import flash_pin_pkg::*;
#(
  parameter bit SHARED_RESET = 1'b0
)(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        selectPin_n,
  input  wire logic        serialClkPin,
  input  wire logic        resetPin_n,
  input  wire logic        pausePin_n,
  input  wire logic [3:0]  dqIn,
  output logic      [3:0]  dqOut,
  output logic      [3:0]  dqOe,
  output logic             standby,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [7:0] pinLevel;
  logic [7:0] pinRise;
  logic [7:0] pinFall;

  edge_sampler #(.WIDTH(8), .IDLE(8'hFC)) sampler (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   ({dqIn, pausePin_n, resetPin_n, serialClkPin, selectPin_n}),
    .level   (pinLevel),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic        armed;
    logic        selected;
    logic        cmdDone;
    logic [2:0]  bitCount;
    logic [7:0]  shiftIn;
    logic [7:0]  shiftOut;
    logic [7:0]  rxData;
    logic        rxValid;
    logic [7:0]  txData;
    logic        dtr;
    logic        qio;
    lane_mode_t  lanes;
    logic        busy;
    logic [7:0]  nvCfg;
    logic [7:0]  evCfg;
    logic [3:0]  dqOut;
    logic [3:0]  dqOe;
    logic        standby;
    bus_state_t  bus;
    logic        awSeen;
    logic        wSeen;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic        awReady;
    logic        wReady;
    logic        arReady;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } front_t;

  front_t st_reg;
  front_t st_next;

  // Lanes used per beat; extended protocol behaves as single lane here.
  function automatic logic [2:0] lane_step(input lane_mode_t m);
    unique case (m)
      dual_io_protocol: lane_step = 3'd2;
      quad_io_protocol: lane_step = 3'd4;
      single_edge_rate_lane, extended_io_protocol: lane_step = 3'd1;
    endcase
  endfunction

  function automatic logic [31:0] read_mux(input front_t s, input logic [7:0] a);
    read_mux = 32'h0000_0000;
    unique case (a)
      `OFS_CONTROL: read_mux = {27'h0, s.lanes, s.busy, s.qio, s.dtr};
      `OFS_STATUS:  read_mux = {26'h0, s.armed, s.cmdDone, s.rxValid, s.standby, s.selected, 1'b0};
      `OFS_RXDATA:  read_mux = {24'h0, s.rxData};
      `OFS_TXDATA:  read_mux = {24'h0, s.txData};
      `OFS_NVCFG:   read_mux = {24'h0, s.nvCfg};
      `OFS_EVCFG:   read_mux = {24'h0, s.evCfg};
      default:      read_mux = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `OFS_CONTROL) || (a == `OFS_STATUS) || (a == `OFS_RXDATA) ||
              (a == `OFS_TXDATA) || (a == `OFS_NVCFG) || (a == `OFS_EVCFG);
  endfunction

  logic selLow;
  logic sckRise;
  logic sckFall;
  logic rstLow;
  logic pauseLow;
  logic rstEnabled;
  logic pauseEnabled;
  logic sampleEdge;
  logic driveEdge;
  logic [2:0] step;
  logic rxSet;

  always_comb
  begin
    selLow       = !pinLevel[0];
    sckRise      = pinRise[1];
    sckFall      = pinFall[1];
    rstEnabled   = st_reg.nvCfg[`CFG_RSTDIS_BIT] && st_reg.evCfg[`CFG_RSTDIS_BIT]
                   && !(SHARED_RESET && st_reg.qio);
    rstLow       = !pinLevel[2] && rstEnabled;
    pauseEnabled = st_reg.nvCfg[`CFG_PAUSEDIS_BIT] && st_reg.evCfg[`CFG_PAUSEDIS_BIT]
                   && !st_reg.qio && !st_reg.dtr;
    pauseLow     = !pinLevel[3] && pauseEnabled;
    sampleEdge   = sckRise || (st_reg.dtr && sckFall && st_reg.cmdDone);
    driveEdge    = sckFall || (st_reg.dtr && sckRise);
    step         = lane_step(st_reg.lanes);

    st_next         = st_reg;
    rxSet           = 1'b0;

    // ****************************************************************
    // Serial side
    // ****************************************************************
    if (pinFall[0])
    begin
      st_next.armed    = 1'b1;
      st_next.selected = 1'b1;
      st_next.standby  = 1'b0;
      st_next.bitCount = 3'd0;
      st_next.cmdDone  = 1'b0;
      st_next.shiftOut = st_reg.txData;
    end
    if (!selLow)
    begin
      st_next.selected = 1'b0;
      st_next.dqOe     = 4'h0;
      st_next.standby  = !st_reg.busy;
    end
    else if (st_reg.selected && st_reg.armed && !pauseLow)
    begin
      if (sampleEdge)
      begin
        unique case (step)
          3'd2:    st_next.shiftIn = {st_reg.shiftIn[5:0], pinLevel[5:4]};
          3'd4:    st_next.shiftIn = {st_reg.shiftIn[3:0], pinLevel[7:4]};
          default: st_next.shiftIn = {st_reg.shiftIn[6:0], pinLevel[4]};
        endcase
        st_next.bitCount = 3'(st_reg.bitCount + step);
        if (3'(st_reg.bitCount + step) == 3'd0)
        begin
          st_next.rxData  = st_next.shiftIn;
          st_next.rxValid = 1'b1;
          rxSet           = 1'b1;
          st_next.cmdDone = 1'b1;
        end
      end
      if (driveEdge && st_reg.cmdDone)
      begin
        unique case (step)
          3'd2:
          begin
            st_next.dqOut    = {2'b00, st_reg.shiftOut[7:6]};
            st_next.dqOe     = 4'h3;
            st_next.shiftOut = {st_reg.shiftOut[5:0], 2'b00};
          end
          3'd4:
          begin
            st_next.dqOut    = st_reg.shiftOut[7:4];
            st_next.dqOe     = 4'hF;
            st_next.shiftOut = {st_reg.shiftOut[3:0], 4'h0};
          end
          default:
          begin
            st_next.dqOut    = {2'b00, st_reg.shiftOut[7], 1'b0};
            st_next.dqOe     = 4'h2;
            st_next.shiftOut = {st_reg.shiftOut[6:0], 1'b0};
          end
        endcase
      end
    end
    else if (pauseLow)
      st_next.dqOe = 4'h0;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    st_next.awReady = 1'b0;
    st_next.wReady  = 1'b0;
    st_next.arReady = 1'b0;
    if (s_axi_awvalid && st_reg.awReady)
    begin
      st_next.awSeen = 1'b1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wReady)
    begin
      st_next.wSeen = 1'b1;
      st_next.wData = s_axi_wdata;
    end
    unique case (st_reg.bus)
      stIdle:
      begin
        if (st_reg.awSeen && st_reg.wSeen)
        begin
          st_next.bus    = stWriteResp;
          st_next.bValid = 1'b1;
          st_next.bResp  = addr_ok(st_reg.awAddr) ? `AXI_OKAY : `AXI_SLVERR;
          st_next.awSeen = 1'b0;
          st_next.wSeen  = 1'b0;
          unique case (st_reg.awAddr)
            `OFS_CONTROL:
            begin
              st_next.dtr   = st_reg.wData[`CTL_DTR_BIT];
              st_next.qio   = st_reg.wData[`CTL_QIO_BIT];
              st_next.busy  = st_reg.wData[`CTL_BUSY_BIT];
              st_next.lanes = lane_mode_t'(st_reg.wData[4:3]);
            end
            `OFS_RXDATA: st_next.rxValid = rxSet;
            `OFS_TXDATA: st_next.txData = st_reg.wData[7:0];
            `OFS_NVCFG:  st_next.nvCfg = st_reg.wData[7:0];
            `OFS_EVCFG:  st_next.evCfg = st_reg.wData[7:0];
            default: ;
          endcase
        end
        else if (s_axi_arvalid && !st_reg.arReady)
        begin
          st_next.arReady = 1'b1;
          st_next.bus     = stRead;
          st_next.rValid  = 1'b1;
          st_next.rData   = read_mux(st_reg, s_axi_araddr);
          st_next.rResp   = addr_ok(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
        end
        else
        begin
          st_next.awReady = !st_reg.awSeen && !st_reg.awReady;
          st_next.wReady  = !st_reg.wSeen && !st_reg.wReady;
        end
      end
      stRead:
        if (s_axi_rready)
        begin
          st_next.rValid = 1'b0;
          st_next.bus    = stIdle;
        end
      stWriteResp:
        if (s_axi_bready)
        begin
          st_next.bValid = 1'b0;
          st_next.bus    = stIdle;
        end
      default: st_next.bus = stIdle;
    endcase

    // Reset pin wins over arming, selection, bit count, command state and lane enables on the serial side.
    if (rstLow)
    begin
      st_next.armed    = 1'b0;
      st_next.selected = 1'b0;
      st_next.cmdDone  = 1'b0;
      st_next.bitCount = 3'd0;
      st_next.dqOe     = 4'h0;
      st_next.busy     = 1'b0;
      st_next.evCfg    = `CFG_RESET;
      st_next.dtr      = 1'b0;
      st_next.qio      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg         <= '0;
      st_reg.standby <= 1'b1;
      st_reg.nvCfg   <= `CFG_RESET;
      st_reg.evCfg   <= `CFG_RESET;
    end
    else
      st_reg <= st_next;
  end

  assign dqOut         = st_reg.dqOut;
  assign dqOe          = st_reg.dqOe;
  assign standby       = st_reg.standby;
  assign s_axi_awready = st_reg.awReady;
  assign s_axi_wready  = st_reg.wReady;
  assign s_axi_bvalid  = st_reg.bValid;
  assign s_axi_bresp   = st_reg.bResp;
  assign s_axi_arready = st_reg.arReady;
  assign s_axi_rvalid  = st_reg.rValid;
  assign s_axi_rdata   = st_reg.rData;
  assign s_axi_rresp   = st_reg.rResp;
endmodule

/* File: flash_pin_front_asserts.sv */
/*
  Concurrent checks on the pins and register bus of the flash pin front end.
  Assumes it is bound to flash_pin_front and sees only that module's ports.
*/
`timescale 1ns/1ps
module flash_pin_front_asserts
  import flash_pin_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        selectPin_n,
  input wire logic [3:0]  dqOe,
  input wire logic        standby,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_desel_tristate: assert property (selectPin_n [*5] |-> dqOe == 4'h0)
    else $error("lanes driven while deselected");
  chk_sel_active: assert property ($fell(selectPin_n) ##1 !selectPin_n [*4] |-> !standby)
    else $error("standby while selected");
  chk_standby_cause: assert property ($rose(standby) |-> $past(selectPin_n))
    else $error("standby without deselect");
  chk_drive_selected: assert property ($rose(dqOe[1]) |-> !selectPin_n && !$past(selectPin_n))
    else $error("lane 1 driven without select");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> s_axi_rvalid)
    else $error("read answer late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(dqOe[1]));
endmodule

bind flash_pin_front flash_pin_front_asserts i_chk (.clk, .reset_n, .selectPin_n, .dqOe, .standby,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* File: flash_pin_map.svh */
/*
  Constants for the serial flash pin front end: register offsets, field
  positions and reset values.
  Assumes inclusion by bare name from the package and the bench.
*/
`ifndef FLASH_PIN_MAP_SVH
`define FLASH_PIN_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CONTROL    8'h00
`define OFS_STATUS     8'h04
`define OFS_RXDATA     8'h08
`define OFS_TXDATA     8'h0C
`define OFS_NVCFG      8'h10
`define OFS_EVCFG      8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CTL_DTR_BIT    0
`define CTL_QIO_BIT    1
`define CTL_BUSY_BIT   2
`define CFG_RSTDIS_BIT 4
`define CFG_PAUSEDIS_BIT 4

// ****************************************************************
// Reset values and AXI responses
// ****************************************************************
`define CONTROL_RESET  32'h0000_0000
`define CFG_RESET      8'hFF
`define AXI_OKAY       2'b00
`define AXI_SLVERR     2'b10

`endif

/* File: flash_pin_pkg.sv */
/*
  Types shared by the serial flash pin front end.
  Assumes the map header is on the include path.
*/
package flash_pin_pkg;
  `include "flash_pin_map.svh"

  typedef enum logic [1:0] {
    single_edge_rate_lane,
    dual_io_protocol,
    quad_io_protocol,
    extended_io_protocol
  } lane_mode_t;

  typedef enum logic [1:0] {
    stIdle,
    stRead,
    stWriteResp
  } bus_state_t;
endpackage

/* File: serial_flash_pin_interface_bench.sv */
/*
  Self-checking bench: an AXI4-Lite master, the host model on the flash pins
  and a watcher that checks bus answers in order against queued notes.
  Assumes the package, map header, host model and checker are compiled first.
*/
`timescale 1ns/1ps
`include "flash_pin_map.svh"
`define CHECK(what, exp, got) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) \
    begin \
      errorCnt++; \
      $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
  end
module serial_flash_pin_interface_bench
  import flash_pin_pkg::*;
;
  typedef struct {string what; logic [33:0] exp; logic [33:0] mask;} note_t;
  note_t       expQ[$];
  note_t       note;
  int          errorCnt      = 0;
  int          nCompared     = 0;
  logic        clk           = 1'b0;
  logic        reset_n       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        selectPin_n, serialClkPin, resetPin_n, pausePin_n, standby;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0]  dqIn, dqOut, dqOe;

  always #5 clk = ~clk;

  flash_pin_front i_dut (.clk, .reset_n, .selectPin_n, .serialClkPin, .resetPin_n, .pausePin_n, .dqIn,
    .dqOut, .dqOe, .standby, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  flash_host_model i_host (.clk, .selectPin_n, .serialClkPin, .resetPin_n, .pausePin_n, .dqIn, .dqOut,
    .dqOe);

  // ****
  // Tasks
  // ****
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Requests are held until their own ready; the answer ends the wait.
  task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e,
                     input logic [33:0] m, input string what);
    int n;
    expQ.push_back('{what, e & m, m});
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    // One idle edge keeps the next request off the edge of this release.
    @(posedge clk);
    if (n == 40)
    begin
      errorCnt++;
      endOfTest();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi(1'b1, a, d, {`AXI_OKAY, 32'h0}, 34'h3_0000_0000, "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m, input string what);
    axi(1'b0, a, 32'h0, e, m, what);
  endtask

  always @(posedge clk)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      note = expQ.pop_front();
      `CHECK(note.what, note.exp, {(s_axi_bvalid ? s_axi_bresp : s_axi_rresp), s_axi_rdata} & note.mask)
    end

  // ****
  // Scenarios
  // ****
  initial
  begin
    logic [7:0] txb;
    logic [7:0] rxb;
    logic [7:0] got;
    void'($urandom(32'h2CAE));
    txb = 8'($urandom);
    rxb = 8'($urandom);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`OFS_CONTROL, {`AXI_OKAY, `CONTROL_RESET}, '1, "control");
    rd(`OFS_EVCFG, {`AXI_OKAY, 24'h0, `CFG_RESET}, 34'h3_0000_00FF, "evcfg");
    rd(8'h18, {`AXI_SLVERR, 32'h0}, '1, "unmapped");
    i_host.xfer(rxb, got);
    @(posedge clk);
    rd(`OFS_STATUS, {`AXI_OKAY, 32'h0}, 34'h3_0000_0028, "status unarmed");
    i_host.selectPin_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHECK("dqOe", 4'h0, dqOe)
    `CHECK("standby", 1'b1, standby)
    i_host.xfer(rxb, got);
    @(posedge clk);
    wr(`OFS_TXDATA, {24'h0, txb});
    i_host.selectPin_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`OFS_STATUS, {`AXI_OKAY, 32'h22}, 34'h3_0000_002E, "status selected");
    i_host.xfer(rxb, got);
    i_host.slowBy = 2;
    i_host.xfer(rxb, got);
    i_host.slowBy = 1;
    `CHECK("lane 1 byte", txb, got)
    @(posedge clk);
    rd(`OFS_RXDATA, {`AXI_OKAY, 24'h0, rxb}, 34'h3_0000_00FF, "rx byte");
    i_host.pausePin_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHECK("dqOe paused", 4'h0, dqOe)
    i_host.pausePin_n <= 1'b1;
    $display("test frame done");
    wr(`OFS_CONTROL, 32'h4);
    i_host.selectPin_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHECK("standby busy", 1'b0, standby)
    wr(`OFS_CONTROL, 32'h0);
    repeat (6) @(posedge clk);
    `CHECK("standby idle", 1'b1, standby)
    $display("test standby done");
    // Pass 0 keeps the reset pin live; passes 1 and 2 disable it by either register.
    for (int k = 0; k < 3; k++)
    begin
      if (k > 0)
        wr(k == 1 ? `OFS_NVCFG : `OFS_EVCFG, 32'hEF);
      wr(`OFS_CONTROL, 32'h1);
      i_host.resetPin_n <= 1'b0;
      repeat (6) @(posedge clk);
      `CHECK("dqOe in reset", 4'h0, dqOe)
      i_host.resetPin_n <= 1'b1;
      repeat (6) @(posedge clk);
      rd(`OFS_CONTROL, {`AXI_OKAY, 31'h0, k > 0}, 34'h3_0000_0001, "control after pin reset");
      if (k > 0)
        wr(k == 1 ? `OFS_NVCFG : `OFS_EVCFG, 32'hFF);
    end
    $display("test reset pin done");
    for (int m = 0; m < 4; m++)
    begin
      wr(`OFS_CONTROL, 32'(m) << 3 | 32'h3);
      rd(`OFS_CONTROL, {`AXI_OKAY, 32'(m) << 3 | 32'h3}, 34'h3_0000_001B, "lane mode");
    end
    $display("test modes done");
    endOfTest();
  end
endmodule
